//--- core/err_mgr_cfg.svh
// constants for the dispenser error manager
`ifndef ERR_MGR_CFG_SVH
`define ERR_MGR_CFG_SVH
`define CLK_HZ          50000000
`define POLL_LIMIT_S    5
`define PULSE_LIMIT_S   6
`define POLL_CYCLES     (`POLL_LIMIT_S * `CLK_HZ)
`define PULSE_CYCLES    (`PULSE_LIMIT_S * `CLK_HZ)
`define RETRY_LIMIT     3
`define N_FATAL         7
`define N_SOFT          9
// soft fault indices
`define S_DISP1   0
`define S_DISP2   1
`define S_LINK    2
`define S_SETUP   3
`define S_PRESS   4
`define S_FLOW    5
`define S_TEMP    6
`define S_PSENS   7
`define S_PULSER  8
`define NO_CODE   16'h0000
`endif

//--- core/err_mgr_pkg.sv
// types shared by the error manager files
package err_mgr_pkg;
  typedef logic [15:0] host_code_t;  // two ascii characters
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,  // no error
    ST_SOFT  = 3'b010,  // non-fatal active
    ST_FATAL = 3'b100   // latched until power-off
  } err_state_e;
endpackage : err_mgr_pkg

//--- core/timeout_counter.sv
// watchdog counter: expires when kick is absent for limit cycles
`timescale 1ns/100ps
module timeout_counter #(
  parameter int unsigned LIMIT = 1000
) (
  input  wire logic mclk_in,     // system clock
  input  wire logic rst_b_in,    // sync reset, active low
  input  wire logic run_in,      // counting allowed
  input  wire logic kick_in,     // restart the count
  output logic      expired_out  // limit reached, level
);
  localparam int W = $clog2(LIMIT + 1);
  logic [W-1:0] cnt_q;  // elapsed cycles
  logic [W-1:0] cnt_d;
  logic         exp_q;
  logic         exp_d;
  // next count
  always_comb begin
    cnt_d = cnt_q;
    exp_d = exp_q;
    if (!run_in || kick_in) begin
      cnt_d = '0;
      exp_d = 1'b0;
    end else if (cnt_q >= W'(LIMIT - 1)) begin
      exp_d = 1'b1;
    end else begin
      cnt_d = cnt_q + W'(1);
    end
  end
  // registers
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end
  assign expired_out = exp_q;
endmodule : timeout_counter

//--- core/dispenser_error_manager.sv
// error supervision: classify, stop delivery, show and report codes
`timescale 1ns/100ps
`include "err_mgr_cfg.svh"
module dispenser_error_manager
  import err_mgr_pkg::*;
#(
  parameter int unsigned POLL_CYCLES  = `POLL_CYCLES,
  parameter int unsigned PULSE_CYCLES = `PULSE_CYCLES,
  parameter int unsigned RETRIES      = `RETRY_LIMIT
) (
  input  wire logic        mclk_in,           // system clock 50 MHz
  input  wire logic        rst_b_in,          // power-on reset, low
  input  wire logic [6:0]  fatal_fault_in,    // inherent fatal causes
  input  wire logic [8:0]  soft_fault_in,     // field causes, 2 from link
  input  wire logic        host_present_in,   // host attached
  input  wire logic        host_poll_in,      // one pulse per poll
  input  wire logic        valve_open_in,     // solenoid valve open
  input  wire logic        flow_pulse_in,     // pulser pulse
  input  wire logic        restart_req_in,    // restart attempt pulse
  input  wire logic        restart_ok_in,     // restart delivered flow
  output logic             halt_out,          // stop delivery
  output logic             fatal_out,         // latched fatal
  output logic [4:0]       show_code_out,     // displayed error index
  output logic             show_fatal_out,    // display fatal form
  output logic             report_out,        // host code valid
  output logic [7:0]       code_first_out,    // first ascii byte
  output logic [7:0]       code_second_out    // second ascii byte
);
  // fatal code table, by fatal index
  function automatic host_code_t fatal_code(input logic [4:0] i);
    case (i)
      5'h00:   fatal_code = 16'h3330;  // data congruence 30
      5'h01:   fatal_code = 16'h3131;  // program memory 11
      5'h02:   fatal_code = 16'h3130;  // ram 10
      5'h03:   fatal_code = 16'h3135;  // nonvolatile 15
      5'h04:   fatal_code = 16'h3232;  // totalizer 22
      5'h05:   fatal_code = 16'h3437;  // spare inputs 47
      5'h06:   fatal_code = 16'h3432;  // mass flow meter 42
      default: fatal_code = `NO_CODE;
    endcase
  endfunction : fatal_code
  // promoted soft codes
  function automatic host_code_t promo_code(input logic [4:0] i);
    case (i)
      5'h00, 5'h01: promo_code = 16'h4730;  // displays G0
      5'h04:   promo_code = 16'h4434;  // pressure D4
      5'h05:   promo_code = 16'h4737;  // high flow G7
      5'h06:   promo_code = 16'h4436;  // temp sensor D6
      5'h07:   promo_code = 16'h4435;  // pressure sensor D5
      5'h08:   promo_code = 16'h4731;  // pulser G1
      default: promo_code = `NO_CODE;
    endcase
  endfunction : promo_code
  // active soft codes
  function automatic host_code_t soft_code(input logic [4:0] i);
    case (i)
      5'h00, 5'h01: soft_code = 16'h3032;  // displays 02
      5'h02:   soft_code = 16'h3830;  // host link 80
      5'h03:   soft_code = 16'h3431;  // setup missing 41
      5'h04:   soft_code = 16'h3434;  // pressure 44
      5'h05:   soft_code = 16'h3737;  // high flow 77
      5'h06:   soft_code = 16'h3436;  // temp sensor 46
      5'h07:   soft_code = 16'h3435;  // pressure sensor 45
      5'h08:   soft_code = 16'h3731;  // pulser 71
      default: soft_code = `NO_CODE;
    endcase
  endfunction : soft_code
  // lowest set bit index of a 9-bit vector
  function automatic logic [4:0] first_set(input logic [8:0] v);
    first_set = 5'h00;
    for (int k = 8; k >= 0; k--) begin
      if (v[k]) first_set = 5'(k);
    end
  endfunction : first_set

  logic link_to;    // poll watchdog expired
  logic pulse_to;   // pulser watchdog expired
  // host poll watchdog, only while a host is attached
  timeout_counter #(.LIMIT(POLL_CYCLES)) u_poll_wd (
    .mclk_in     (mclk_in),
    .rst_b_in    (rst_b_in),
    .run_in      (host_present_in),
    .kick_in     (host_poll_in),
    .expired_out (link_to)
  );
  logic pulse_seen_q;  // a pulse arrived since valve opened
  logic pulse_seen_d;
  // pulser watchdog counts from valve opening until first pulse
  always_comb begin
    pulse_seen_d = pulse_seen_q;
    if (!valve_open_in) pulse_seen_d = 1'b0;
    else if (flow_pulse_in) pulse_seen_d = 1'b1;
  end
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) pulse_seen_q <= 1'b0;
    else pulse_seen_q <= pulse_seen_d;
  end
  timeout_counter #(.LIMIT(PULSE_CYCLES)) u_pulse_wd (
    .mclk_in     (mclk_in),
    .rst_b_in    (rst_b_in),
    .run_in      (valve_open_in & ~pulse_seen_q),
    .kick_in     (flow_pulse_in),
    .expired_out (pulse_to)
  );

  logic [8:0] soft_all;  // every live non-fatal cause
  always_comb begin
    soft_all = soft_fault_in;
    soft_all[`S_LINK]   = soft_fault_in[`S_LINK] | link_to;
    soft_all[`S_PULSER] = soft_fault_in[`S_PULSER] | pulse_to;
  end

  err_state_e st_q;      // class state
  err_state_e st_d;
  logic [4:0] idx_q;     // error index shown
  logic [4:0] idx_d;
  logic       promo_q;   // fatal came from promotion
  logic       promo_d;
  logic [1:0] tries_q;   // failed restart attempts
  logic [1:0] tries_d;
  logic [15:0] code_q;   // host code register
  logic [15:0] code_d;
  logic       rep_q;
  logic       rep_d;
  // classification, retry and latch logic
  always_comb begin
    st_d    = st_q;
    idx_d   = idx_q;
    promo_d = promo_q;
    tries_d = tries_q;
    case (st_q)
      ST_IDLE: begin
        if (|fatal_fault_in) begin
          st_d    = ST_FATAL;
          idx_d   = first_set({2'b00, fatal_fault_in});
          promo_d = 1'b0;
        end else if (|soft_all) begin
          st_d  = ST_SOFT;
          idx_d = first_set(soft_all);
        end else if (restart_ok_in) begin
          tries_d = 2'd0;
        end
      end
      ST_SOFT: begin
        if (|fatal_fault_in) begin
          st_d    = ST_FATAL;
          idx_d   = first_set({2'b00, fatal_fault_in});
          promo_d = 1'b0;
        end else if (restart_req_in && (|soft_all)) begin
          if (tries_q >= 2'(RETRIES)) begin
            st_d    = ST_FATAL;
            promo_d = 1'b1;
          end else begin
            tries_d = tries_q + 2'd1;
          end
        end else if (!(|soft_all)) begin
          st_d = ST_IDLE;
        end else begin
          idx_d = first_set(soft_all);
        end
      end
      ST_FATAL: st_d = ST_FATAL;
      default:  st_d = ST_IDLE;
    endcase
  end
  // host code next value
  always_comb begin
    code_d = `NO_CODE;
    rep_d  = 1'b0;
    if (host_present_in && st_d != ST_IDLE) begin
      rep_d = 1'b1;
      if (st_d == ST_SOFT) code_d = soft_code(idx_d);
      else if (promo_d) code_d = promo_code(idx_d);
      else code_d = fatal_code(idx_d);
    end
  end
  // state registers
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      st_q    <= ST_IDLE;
      idx_q   <= 5'h00;
      promo_q <= 1'b0;
      tries_q <= 2'd0;
      code_q  <= `NO_CODE;
      rep_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      idx_q   <= idx_d;
      promo_q <= promo_d;
      tries_q <= tries_d;
      code_q  <= code_d;
      rep_q   <= rep_d;
    end
  end
  assign halt_out        = (st_q != ST_IDLE);
  assign fatal_out       = (st_q == ST_FATAL);
  assign show_code_out   = idx_q;
  assign show_fatal_out  = (st_q == ST_FATAL);
  assign report_out      = rep_q;
  assign code_first_out  = code_q[15:8];
  assign code_second_out = code_q[7:0];

  // fatal never leaves
  fatal_latch_a: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    fatal_out |=> fatal_out) else $error("fatal state left");
  // an inherent fatal cause is taken on the next edge
  fatal_class_a: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    (|fatal_fault_in) |=> fatal_out) else $error("fatal not taken");
  // any live cause stops delivery one edge later
  halt_on_err_a: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    ((|fatal_fault_in) || (|soft_all)) |=> halt_out)
    else $error("no halt");
  // non-fatal clears once every cause is gone
  soft_clear_a: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    (st_q == ST_SOFT && soft_all == 9'h000 && fatal_fault_in == 7'h00
     && !restart_req_in) |=> !halt_out) else $error("no clear");
  // last tolerated attempt used up, cause still live, no inherent fatal
  sequence retry_fail_s;
    st_q == ST_SOFT && tries_q == 2'(RETRIES) && restart_req_in
    && (|soft_all) && !(|fatal_fault_in);
  endsequence
  retry_promo_a: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    retry_fail_s |=> fatal_out && promo_q) else $error("no promote");
  // successful restart while idle forgets earlier failures
  retry_reset_a: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    (st_q == ST_IDLE && restart_ok_in && !(|fatal_fault_in)
     && !(|soft_all)) |=> tries_q == 2'd0) else $error("tries kept");
  // host code tables
  link_code_a: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    (rep_q && !fatal_out && idx_q == 5'(`S_LINK)) |-> code_q == 16'h3830)
    else $error("bad link code");
  promo_code_a: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    (rep_q && promo_q && idx_q == 5'(`S_FLOW)) |-> code_first_out == 8'h47
    && code_second_out == 8'h37) else $error("bad promo code");
  ram_code_a: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    (rep_q && fatal_out && !promo_q && idx_q == 5'd2) |-> code_q == 16'h3130)
    else $error("bad ram code");
  // watchdog expiry stops delivery
  link_err_a: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    $rose(link_to) |=> halt_out) else $error("link lost");
  pulse_err_a: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    $rose(pulse_to) |=> halt_out) else $error("pulser lost");
endmodule : dispenser_error_manager

//--- tb/host_poller.sv
// host model: one-cycle poll pulses at a fixed interval
`timescale 1ns/100ps
module host_poller #(
  parameter int unsigned INTERVAL = 20
) (
  input  wire logic mclk_in,          // system clock
  input  wire logic quiet_in,         // host stops polling
  output logic      poll_out = 1'b0   // one-cycle poll pulse
);
  int unsigned cnt_q = 0;  // cycles since the last poll
  // poll well inside the watchdog limit unless told to keep quiet
  always @(negedge mclk_in) begin
    cnt_q    <= (cnt_q + 1 >= INTERVAL) ? 0 : cnt_q + 1;
    poll_out <= !quiet_in && (cnt_q + 1 >= INTERVAL);
  end
endmodule : host_poller

//--- tb/tb.sv
// self-checking bench for the dispenser error manager
`timescale 1ns/100ps
module tb;
  import err_mgr_pkg::*;
  localparam int unsigned POLL  = 50;  // shortened poll watchdog
  localparam int unsigned PULSE = 60;  // shortened pulser watchdog
  logic       mclk = 1'b0, rst_b = 1'b0, host_present = 1'b1;
  logic [6:0] fatal_fault = '0;
  logic [8:0] soft_fault = '0;
  logic       host_poll, valve_open = 0, flow_pulse = 0, quiet = 0;
  logic       restart_req = 0, restart_ok = 0;
  logic       halt, fatal, show_fatal, report;
  logic [4:0] show_code;
  logic [7:0] code_first, code_second;
  int miscompares = 0, total_checks = 0, cycles = 0;
  // expected host codes per fault index
  logic [15:0] f_code [7] = '{16'h3330, 16'h3131, 16'h3130, 16'h3135,
                              16'h3232, 16'h3437, 16'h3432};
  logic [15:0] s_code [9] = '{16'h3032, 16'h3032, 16'h3830, 16'h3431,
    16'h3434, 16'h3737, 16'h3436, 16'h3435, 16'h3731};
  logic [15:0] p_code [9] = '{16'h4730, 16'h4730, 16'h0000, 16'h0000,
    16'h4434, 16'h4737, 16'h4436, 16'h4435, 16'h4731};
  always #10 mclk = ~mclk;
  host_poller #(.INTERVAL(20)) host (.mclk_in(mclk), .quiet_in(quiet),
    .poll_out(host_poll));
  dispenser_error_manager #(.POLL_CYCLES(POLL), .PULSE_CYCLES(PULSE),
    .RETRIES(3)) dut (.mclk_in(mclk), .rst_b_in(rst_b),
    .fatal_fault_in(fatal_fault), .soft_fault_in(soft_fault),
    .host_present_in(host_present), .host_poll_in(host_poll),
    .valve_open_in(valve_open), .flow_pulse_in(flow_pulse),
    .restart_req_in(restart_req), .restart_ok_in(restart_ok),
    .halt_out(halt), .fatal_out(fatal), .show_code_out(show_code),
    .show_fatal_out(show_fatal), .report_out(report),
    .code_first_out(code_first), .code_second_out(code_second));
  // compare one value and count it
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask : step
  // one failing restart attempt
  task automatic req();
    restart_req = 1;
    step(1);
    restart_req = 0;
    step(2);
  endtask : req
  task automatic do_reset();
    fatal_fault = '0;
    soft_fault  = '0;
    rst_b = 0;
    step(3);
    rst_b = 1;
    step(1);
  endtask : do_reset
  // reset leaves every output low
  task automatic t_reset();
    chk({halt, fatal, show_fatal, report, show_code}, 0);
    chk({code_first, code_second}, 0);
  endtask : t_reset
  // each soft cause halts, reports and clears itself
  task automatic t_soft();
    for (int i = 0; i < 9; i++) begin
      soft_fault[i] = 1;
      step(2);
      chk({halt, fatal, report, show_fatal}, 4'hA);
      chk(show_code, i);
      chk({code_first, code_second}, s_code[i]);
      soft_fault[i] = 0;
      step(3);
      chk({halt, report}, 0);
    end
    host_present = 0;
    soft_fault[4] = 1;
    step(2);
    chk({halt, report}, 2'h2);
    soft_fault[4] = 0;
    host_present = 1;
    step(3);
  endtask : t_soft
  // fatal causes latch through cause removal and restart
  task automatic t_fatal();
    for (int i = 0; i < 7; i++) begin
      fatal_fault[i] = 1;
      step(2);
      chk({halt, fatal, show_fatal, report}, 4'hF);
      chk({code_first, code_second}, f_code[i]);
      fatal_fault[i] = 0;
      restart_ok = 1;
      req();
      restart_ok = 0;
      step(5);
      chk({halt, fatal}, 2'h3);
      do_reset();
    end
  endtask : t_fatal
  // three failures tolerated, the fourth promotes
  task automatic t_promote();
    for (int i = 0; i < 9; i++) begin
      soft_fault[i] = 1;
      step(2);
      repeat (3) req();
      chk(fatal, 0);
      req();
      chk({fatal, show_fatal}, 2'h3);
      chk({code_first, code_second}, p_code[i]);
      soft_fault[i] = 0;
      step(3);
      chk(halt, 1);
      do_reset();
    end
  endtask : t_promote
  // a successful restart starts the attempt count again
  task automatic t_retry_clear();
    soft_fault[5] = 1;
    step(2);
    repeat (3) req();
    soft_fault[5] = 0;
    step(3);
    restart_ok = 1;
    step(1);
    restart_ok = 0;
    soft_fault[5] = 1;
    step(2);
    repeat (3) req();
    chk(fatal, 0);
    req();
    chk(fatal, 1);
    do_reset();
  endtask : t_retry_clear
  // missing polls and missing pulses raise soft errors
  task automatic t_watch();
    quiet = 1;
    step(POLL + 10);
    chk({halt, fatal, report}, 3'h5);
    chk({code_first, code_second}, s_code[2]);
    quiet = 0;
    step(30);
    chk(halt, 0);
    valve_open = 1;
    step(PULSE + 10);
    chk({halt, fatal, report}, 3'h5);
    chk({code_first, code_second}, s_code[8]);
    valve_open = 0;
    step(3);
    chk(halt, 0);
    valve_open = 1;
    repeat (10) begin
      flow_pulse = 1;
      step(1);
      flow_pulse = 0;
      step(9);
    end
    chk(halt, 0);
    valve_open = 0;
  endtask : t_watch
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  // cut a hang short
  always @(posedge mclk) begin
    cycles++;
    if (cycles >= 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    step(3);
    rst_b = 1;
    step(1);
    t_reset();
    t_soft();
    t_fatal();
    t_promote();
    t_retry_clear();
    t_watch();
    end_of_test();
  end
endmodule : tb
